// ---- shared/gtm_pkg.sv ----
package gtm_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int GTM_ADDR_W = 8;
    localparam int GTM_DATA_W = 16;
    localparam int GTM_NUM_PROF = 4;
    localparam int GTM_NUM_SLOT = 10;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] GTM_OFS_P0_LIMITS = 8'ha1;
    localparam logic [7:0] GTM_OFS_P0_STEPS = 8'ha2;
    localparam logic [7:0] GTM_OFS_P1_LIMITS = 8'ha6;
    localparam logic [7:0] GTM_OFS_P1_STEPS = 8'ha7;
    localparam logic [7:0] GTM_OFS_P2_LIMITS = 8'hab;
    localparam logic [7:0] GTM_OFS_P2_STEPS = 8'hac;
    localparam logic [7:0] GTM_OFS_P3_LIMITS = 8'hb0;
    localparam logic [7:0] GTM_OFS_P3_STEPS = 8'hb1;
    localparam logic [7:0] GTM_OFS_ATTEN01 = 8'hb9;
    localparam logic [7:0] GTM_OFS_ATTEN23 = 8'hba;
    // slot order: limits/steps per profile, then two attenuation words
    localparam logic [9:0][7:0] GTM_SLOT_ADDR = {
        GTM_OFS_ATTEN23, GTM_OFS_ATTEN01,
        GTM_OFS_P3_STEPS, GTM_OFS_P3_LIMITS,
        GTM_OFS_P2_STEPS, GTM_OFS_P2_LIMITS,
        GTM_OFS_P1_STEPS, GTM_OFS_P1_LIMITS,
        GTM_OFS_P0_STEPS, GTM_OFS_P0_LIMITS};

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] GTM_RST_LIMITS = 16'h009f;
    localparam logic [15:0] GTM_RST_STEPS = 16'h00f8;
    localparam logic [15:0] GTM_RST_ATTEN = 16'h0000;

    // ----------------------------------------
    // mode codes and gain constants
    // ----------------------------------------
    localparam logic [1:0] GTM_MODE_EXT = 2'h0;
    localparam logic [1:0] GTM_MODE_RAMP = 2'h1;
    localparam logic [1:0] GTM_MODE_FIXED = 2'h2;
    localparam logic [1:0] GTM_MODE_INT = 2'h3;
    localparam logic [8:0] GTM_GAIN_MAX = 9'h13f;
    localparam logic [8:0] GTM_ATTEN_SPAN = 9'h040;
    localparam logic [8:0] GTM_BASE_X8_NORMAL = 9'h030;
    localparam logic [8:0] GTM_BASE_X8_LOWPWR = 9'h060;
    localparam logic [6:0] GTM_RATE_TOP = 7'h7f;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] init_gain;
        logic [7:0] ceil_gain;
        logic [4:0] rise_step;
        logic [2:0] rise_rate;
        logic [4:0] fall_step;
        logic [2:0] fall_rate;
        logic hold_atten;
        logic [6:0] atten_level;
    } gtm_profile_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } gtm_reg_req_t;

    typedef struct packed {
        logic [8:0] gain_code;
        logic [6:0] atten_set;
        logic [7:0] lna_set;
        logic [8:0] gain_db_x8;
    } gtm_gain_out_t;

    typedef enum logic [3:0] {
        GTM_ST_START = 4'b0001,
        GTM_ST_RISE = 4'b0010,
        GTM_ST_HOLD = 4'b0100,
        GTM_ST_FALL = 4'b1000
    } gtm_stage_t;

endpackage : gtm_pkg

// ---- design/gtm_prof_mem.sv ----
`timescale 1ns/10ps
module gtm_prof_mem import gtm_pkg::*; (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register access
    input wire gtm_reg_req_t i_req,
    output gtm_pkg::gtm_profile_t o_prof,
    input wire logic [1:0] i_prof_sel,
    output logic [15:0] o_rdata
);

    // ----------------------------------------
    // storage and decode
    // ----------------------------------------
    logic [GTM_NUM_SLOT-1:0][15:0] word_r; // profile words
    logic [GTM_NUM_SLOT-1:0] hit; // one-hot address match
    logic [15:0] rd_mux; // read select
    logic [15:0] lim_w; // selected limits word
    logic [15:0] stp_w; // selected steps word
    logic [15:0] att_w; // shared attenuation word
    logic [7:0] att_half; // this profile's half

    genvar g;
    generate
        for (g = 0; g < GTM_NUM_SLOT; g++) begin : g_slot
            localparam logic [15:0] RST = (g >= 8) ? GTM_RST_ATTEN :
                (g % 2 == 0) ? GTM_RST_LIMITS : GTM_RST_STEPS;
            assign hit[g] = (i_req.addr == GTM_SLOT_ADDR[g]);
            // each slot loads on its own address
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    word_r[g] <= RST;
                end else if (i_ce && i_req.wr && hit[g]) begin
                    word_r[g] <= i_req.wdata;
                end
            end
        end
    endgenerate

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 16'h0000;
        for (int k = 0; k < GTM_NUM_SLOT; k++) begin
            if (hit[k]) begin
                rd_mux = word_r[k];
            end
        end
    end

    assign lim_w = word_r[{i_prof_sel, 1'b0}];
    assign stp_w = word_r[{i_prof_sel, 1'b1}];
    assign att_w = word_r[4'h8 + {3'h0, i_prof_sel[1]}];
    // even profile owns the upper byte
    assign att_half = i_prof_sel[0] ? att_w[7:0] : att_w[15:8];

    // ----------------------------------------
    // registered read ports
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
            o_prof <= '0;
        end else if (i_ce) begin
            o_rdata <= rd_mux;
            o_prof <= {lim_w[15:8], lim_w[7:0], stp_w[15:11], stp_w[10:8],
                       stp_w[7:3], stp_w[2:0], att_half};
        end
    end

endmodule : gtm_prof_mem

// ---- design/gtm_gain_engine.sv ----
// Function
// - two-bit mode field selects four schemes
// - fixed mode applies direct gain code
// - codes below 64 attenuator, rest LNA
// - fixed code above 319 becomes zero
// - gain dB base 6 or 12 plus eighths
// - reset or ramp entry loads initial gain
// - trigger pin starts rise by rise step plus one
// - rise stops and holds at ceiling
// - pins ignored while rising
// - reverse pin starts fall by fall step plus one
// - fall ends at initial, back to start
// - ramp profile change only in start stage, other schemes follow the live profile
// - profile is two words plus byte
// - initial gain bits 15-8, reset zero
// - ceiling gain bits 7-0, reset 159
// - rise step bits 15-11, reset zero
// - rate N steps every 2^(7-N) clocks
// - fall step bits 7-3, reset 31
// - per-profile hold attenuator enable bit
// - attenuator level N when hold set
// - engine runs on sample clock
// - pins or register choose profile
`timescale 1ns/10ps
module gtm_gain_engine import gtm_pkg::*; #(
    parameter int GAIN_W = 9
) (
    // clock, reset and enable
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // decoded serial register port
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    // control bits
    input wire logic i_gain_map_write_enable,
    input wire logic [1:0] i_gain_scheme_select,
    input wire logic [8:0] i_direct_gain_code,
    input wire logic i_low_power_mode,
    input wire logic i_profile_pin_disable,
    input wire logic [1:0] i_profile_register_choice,
    // device pins
    input wire logic [1:0] i_profile_select_pins,
    input wire logic i_ramp_trigger_pin,
    input wire logic i_ramp_reverse_pin,
    // gain outputs
    output logic [GAIN_W-1:0] o_gain_code,
    output logic [6:0] o_atten_setting,
    output logic [7:0] o_lna_setting,
    output logic [8:0] o_gain_db_x8,
    output logic o_hold_atten,
    output logic [3:0] o_ramp_stage
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    gtm_reg_req_t reg_req; // bundled write request
    gtm_profile_t live_prof; // selected profile, registered
    gtm_profile_t frozen_r; // profile used by the ramp
    gtm_profile_t frozen_nxt; // next frozen profile
    gtm_profile_t use_prof; // profile driving outputs

    gtm_gain_out_t out_r; // registered gain outputs
    gtm_gain_out_t out_nxt; // next gain outputs

    gtm_stage_t stage_r; // ramp stage
    gtm_stage_t stage_nxt; // next ramp stage

    logic [8:0] gain_r; // ramp gain, eighth-dB codes
    logic [8:0] gain_nxt; // next ramp gain

    logic [6:0] rate_cnt_r; // step interval counter
    logic [6:0] rate_cnt_nxt; // next counter value

    logic [1:0] mode_prev_r; // mode seen last cycle
    logic [1:0] prof_sel; // active profile number

    logic trig_s1_r; // trigger sync stage one
    logic trig_s2_r; // trigger sync stage two
    logic trig_s3_r; // trigger edge history

    logic rev_s1_r; // reverse sync stage one
    logic rev_s2_r; // reverse sync stage two
    logic rev_s3_r; // reverse edge history

    logic trig_edge; // trigger went high
    logic rev_edge; // reverse went high

    logic mode_fixed; // fixed gain selected
    logic mode_ramp; // up/down ramp selected
    logic ramp_entry; // ramp just selected

    logic [8:0] init8; // initial gain in eighths
    logic [8:0] ceil8; // ceiling gain in eighths

    logic [8:0] rise_amt; // rise step in eighths
    logic [8:0] fall_amt; // fall step in eighths

    logic [9:0] rise_sum; // unclamped rise result
    logic [8:0] rise_val; // clamped rise result
    logic [8:0] fall_val; // clamped fall result

    logic [6:0] rise_period; // rise interval minus one
    logic [6:0] fall_period; // fall interval minus one
    logic [6:0] cur_period; // interval of this stage

    logic step_tick; // step due this cycle
    logic at_ceil; // rise reached ceiling
    logic at_init; // fall reached initial

    logic [8:0] fixed_code; // checked direct code
    logic [8:0] sel_code; // code before split
    logic [8:0] base_x8; // power-mode gain base

    // ----------------------------------------
    // profile register bank
    // ----------------------------------------
    // writes are dropped unless the host opened the map
    assign reg_req.wr = i_reg_wr & i_gain_map_write_enable;
    assign reg_req.addr = i_reg_addr;
    assign reg_req.wdata = i_reg_wdata;

    // pins or register field pick the profile, same binary code
    assign prof_sel = i_profile_pin_disable ? i_profile_register_choice
                                            : i_profile_select_pins;

    gtm_prof_mem u_prof_mem (
        .i_core_clk (i_core_clk),
        .i_rst_n (i_rst_n),
        .i_ce (i_ce),
        .i_req (reg_req),
        .o_prof (live_prof),
        .i_prof_sel (prof_sel),
        .o_rdata (o_reg_rdata)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // trigger pins may come from another sequencer clock, so two
    // flops are spent even though they are nominally synchronous
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;

            rev_s1_r <= 1'b0;
            rev_s2_r <= 1'b0;
            rev_s3_r <= 1'b0;
        end else if (i_ce) begin
            trig_s1_r <= i_ramp_trigger_pin;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;

            rev_s1_r <= i_ramp_reverse_pin;
            rev_s2_r <= rev_s1_r;
            rev_s3_r <= rev_s2_r;
        end
    end

    // edges compare the second stage against the third
    assign trig_edge = trig_s2_r & ~trig_s3_r;

    assign rev_edge = rev_s2_r & ~rev_s3_r;

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // external and internal non-uniform codes decode but only hold gain
    assign mode_fixed = (i_gain_scheme_select == GTM_MODE_FIXED);
    assign mode_ramp = (i_gain_scheme_select == GTM_MODE_RAMP);

    assign ramp_entry = mode_ramp & (mode_prev_r != GTM_MODE_RAMP);

    // ----------------------------------------
    // ramp arithmetic
    // ----------------------------------------
    // profile limits are quarter-dB codes, the ramp works in eighths
    assign init8 = {frozen_r.init_gain, 1'b0};
    assign ceil8 = {frozen_r.ceil_gain, 1'b0};

    assign rise_amt = {4'h0, frozen_r.rise_step} + 9'h001;

    assign fall_amt = {4'h0, frozen_r.fall_step} + 9'h001;

    assign rise_sum = {1'b0, gain_r} + {1'b0, rise_amt};

    // never step past the ceiling
    assign rise_val = (rise_sum >= {1'b0, ceil8}) ? ceil8 : rise_sum[8:0];

    // never step below the initial gain; compare avoids underflow
    assign fall_val = (gain_r <= init8 + fall_amt) ? init8
                                                   : gain_r - fall_amt;
    assign at_ceil = (gain_r >= ceil8);
    assign at_init = (gain_r <= init8);

    // rate N gives one step every 2^(7-N) clocks
    assign rise_period = GTM_RATE_TOP >> frozen_r.rise_rate;

    assign fall_period = GTM_RATE_TOP >> frozen_r.fall_rate;

    assign cur_period = (stage_r == GTM_ST_FALL) ? fall_period : rise_period;
    assign step_tick = (rate_cnt_r >= cur_period);

    // ----------------------------------------
    // ramp stage logic
    // ----------------------------------------
    // next stage, gain, counter and frozen profile
    always_comb begin
        stage_nxt = stage_r;
        gain_nxt = gain_r;
        rate_cnt_nxt = step_tick ? 7'h00 : rate_cnt_r + 7'h01;
        frozen_nxt = frozen_r;
        if (ramp_entry) begin
            // fresh entry restarts from the live profile
            stage_nxt = GTM_ST_START;
            frozen_nxt = live_prof;
            gain_nxt = {live_prof.init_gain, 1'b0};
            rate_cnt_nxt = 7'h00;
        end else if (mode_ramp) begin
            case (stage_r)
                GTM_ST_START: begin
                    // only here may a new profile take over
                    frozen_nxt = live_prof;
                    gain_nxt = {live_prof.init_gain, 1'b0};
                    rate_cnt_nxt = 7'h00;
                    if (trig_edge) begin
                        stage_nxt = GTM_ST_RISE;
                    end
                end

                GTM_ST_RISE: begin
                    // both pins are ignored until the ceiling
                    if (at_ceil) begin
                        stage_nxt = GTM_ST_HOLD;
                        rate_cnt_nxt = 7'h00;
                    end else if (step_tick) begin
                        gain_nxt = rise_val;
                    end
                end

                GTM_ST_HOLD: begin
                    // parked at the ceiling for the reverse pin
                    rate_cnt_nxt = 7'h00;
                    if (rev_edge) begin
                        stage_nxt = GTM_ST_FALL;
                    end
                end

                GTM_ST_FALL: begin
                    if (at_init) begin
                        stage_nxt = GTM_ST_START;
                    end else if (step_tick) begin
                        gain_nxt = fall_val;
                    end
                end

                default: begin
                    // illegal code recovers to start
                    stage_nxt = GTM_ST_START;
                end
            endcase
        end
    end

    // state registers of the ramp
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stage_r <= GTM_ST_START;
            gain_r <= 9'h000;
            rate_cnt_r <= 7'h00;
            frozen_r <= '0;
            mode_prev_r <= GTM_MODE_EXT;

        end else if (i_ce) begin
            stage_r <= stage_nxt;
            gain_r <= gain_nxt;
            rate_cnt_r <= rate_cnt_nxt;
            frozen_r <= frozen_nxt;
            mode_prev_r <= i_gain_scheme_select;
        end
    end

    // ----------------------------------------
    // gain selection and split
    // ----------------------------------------
    // an out-of-range fixed code is replaced, never saturated
    assign fixed_code = (i_direct_gain_code > GTM_GAIN_MAX) ? 9'h000
                                                            : i_direct_gain_code;
    // fixed code, ramp gain, or hold last value in other schemes
    assign sel_code = mode_fixed ? fixed_code :
                      mode_ramp ? gain_nxt : out_r.gain_code;

    // ramp uses its frozen profile, other schemes the live one
    assign use_prof = mode_ramp ? frozen_nxt : live_prof;

    assign base_x8 = i_low_power_mode ? GTM_BASE_X8_LOWPWR : GTM_BASE_X8_NORMAL;

    // split into attenuator and LNA settings
    always_comb begin
        out_nxt.gain_code = sel_code;
        out_nxt.gain_db_x8 = base_x8 + sel_code;

        if (sel_code < GTM_ATTEN_SPAN) begin
            out_nxt.atten_set = sel_code[6:0];
            out_nxt.lna_set = 8'h00;
        end else begin
            out_nxt.atten_set = GTM_ATTEN_SPAN[6:0];
            out_nxt.lna_set = 8'(sel_code - GTM_ATTEN_SPAN);
        end
        // hold bit pins the attenuator to its own level
        if (use_prof.hold_atten) begin
            out_nxt.atten_set = use_prof.atten_level;
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // outputs follow the next state so they line up with stage_r
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            out_r <= '0;
            o_hold_atten <= 1'b0;

        end else if (i_ce) begin
            out_r <= out_nxt;
            o_hold_atten <= use_prof.hold_atten;
        end
    end

    assign o_gain_code = GAIN_W'(out_r.gain_code);
    assign o_atten_setting = out_r.atten_set;
    assign o_lna_setting = out_r.lna_set;
    assign o_gain_db_x8 = out_r.gain_db_x8;
    assign o_ramp_stage = stage_r;

endmodule : gtm_gain_engine

// ---- bench/gtm_engine_props.sv ----
`timescale 1ns/10ps
module gtm_engine_props import gtm_pkg::*; #(
    parameter int GAIN_W = 9
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // watched controls
    input wire logic i_low_power_mode,
    input wire logic [1:0] i_gain_scheme_select,
    input wire logic [8:0] i_direct_gain_code,
    // watched outputs
    input wire logic [GAIN_W-1:0] o_gain_code,
    input wire logic [6:0] o_atten_setting,
    input wire logic [7:0] o_lna_setting,
    input wire logic [8:0] o_gain_db_x8,
    input wire logic o_hold_atten,
    input wire logic [3:0] o_ramp_stage
);
    // ---
    // shared clocking
    // ---
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic ramp_w = (i_gain_scheme_select == GTM_MODE_RAMP);
    wire logic fix_w = (i_gain_scheme_select == GTM_MODE_FIXED);

    // ---
    // gain mapping and ramp stages
    // ---
    fixed_code_a: assert property (
        fix_w |=> o_gain_code == (($past(i_direct_gain_code) > GTM_GAIN_MAX) ? 9'h0
            : $past(i_direct_gain_code))) else $error("fixed gain code wrong");
    atten_low_a: assert property (
        o_gain_code < 64 && !o_hold_atten |-> o_atten_setting == o_gain_code[6:0]
            && o_lna_setting == 8'h0) else $error("attenuator split wrong");
    lna_high_a: assert property (
        o_gain_code >= 64 |-> o_lna_setting == o_gain_code - 64
            && (o_hold_atten || o_atten_setting == 7'h40)) else $error("lna split wrong");
    db_base_a: assert property (
        $past(i_rst_n) && $stable(i_low_power_mode) |-> o_gain_db_x8 == o_gain_code
            + (i_low_power_mode ? 9'h060 : 9'h030)) else $error("gain in dB wrong");
    gain_max_a: assert property (
        o_gain_code <= GTM_GAIN_MAX) else $error("gain code above range");
    reset_start_a: assert property (
        $rose(i_rst_n) |-> o_ramp_stage == GTM_ST_START && o_gain_code == 0)
        else $error("reset state wrong");

    rise_keep_a: assert property (
        ramp_w && o_ramp_stage == GTM_ST_RISE |=> o_ramp_stage inside {GTM_ST_RISE,
            GTM_ST_HOLD} && o_gain_code >= $past(o_gain_code)) else $error("rise broken");
    hold_keep_a: assert property (
        ramp_w && o_ramp_stage == GTM_ST_HOLD |=> o_ramp_stage inside {GTM_ST_HOLD,
            GTM_ST_FALL} && $stable(o_gain_code)) else $error("hold broken");
    fall_down_a: assert property (
        ramp_w && o_ramp_stage == GTM_ST_FALL |=> o_ramp_stage inside {GTM_ST_FALL,
            GTM_ST_START} && o_gain_code <= $past(o_gain_code)) else $error("fall broken");
    start_keep_a: assert property (
        ramp_w && o_ramp_stage == GTM_ST_START |=> o_ramp_stage inside {GTM_ST_START,
            GTM_ST_RISE}) else $error("start stage left wrongly");
endmodule : gtm_engine_props

// ---- bench/gtm_host_model.sv ----
`timescale 1ns/10ps
module gtm_host_model import gtm_pkg::*; (
    // clock
    input wire logic i_core_clk,
    // register port towards the device
    output gtm_reg_req_t o_req,
    output logic o_wr_en,
    input wire logic [15:0] i_rdata,
    // ramp pins
    output logic o_trig,
    output logic o_rev
);
    // idle host
    initial begin
        o_req = '0;
        o_wr_en = 1'b0;
        o_trig = 1'b0;
        o_rev = 1'b0;
    end

    // ---
    // write: enable a cycle ahead of strobe
    // ---
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data, input logic en);
        @(negedge i_core_clk);
        o_wr_en <= en;
        @(negedge i_core_clk);
        o_req <= '{wr: 1'b1, addr: addr, wdata: data};
        @(negedge i_core_clk);
        o_req.wr <= 1'b0;
        o_wr_en <= 1'b0;
    endtask : write_reg

    // read answer is registered one edge after the address
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(negedge i_core_clk);
        o_req.addr <= addr;
        @(negedge i_core_clk);
        data = i_rdata;
    endtask : read_reg

    // pin levels change off the sampling edge
    task automatic set_pins(input logic trig, input logic rev);
        @(negedge i_core_clk);
        o_trig <= trig;
        o_rev <= rev;
    endtask : set_pins
endmodule : gtm_host_model

// ---- bench/test_time_gain_ramp_engine.sv ----
`timescale 1ns/10ps
module test_time_gain_ramp_engine import gtm_pkg::*;;
    // ---
    // signals
    // ---
    logic clk = 1'b0; // 40 MHz sample clock
    logic rst_n = 1'b0; // sync reset, active low
    logic [1:0] mode = GTM_MODE_FIXED; // gain scheme
    logic [8:0] code = 9'h0; // direct gain code
    logic lp = 1'b0; // low power mode
    logic pdis = 1'b0; // profile from register when set
    logic [1:0] choice = 2'h0; // register profile choice
    logic [1:0] pins = 2'h0; // profile pins
    gtm_reg_req_t req;
    logic wr_en, trig, rev, hold;
    logic [15:0] rdata, rd;
    logic [8:0] gain, db;
    logic [6:0] atten;
    logic [7:0] lna;
    logic [3:0] stage;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int lo [6] = '{0, 63, 64, 319, 320, 511}; // boundary codes
    logic [8:0] eff;

    initial begin
        forever #12.5 clk = ~clk;
    end

    gtm_host_model host_u (.i_core_clk(clk), .o_req(req), .o_wr_en(wr_en), .i_rdata(rdata),
        .o_trig(trig), .o_rev(rev));
    gtm_gain_engine #(.GAIN_W(9)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_reg_wr(req.wr), .i_reg_addr(req.addr), .i_reg_wdata(req.wdata), .o_reg_rdata(rdata),
        .i_gain_map_write_enable(wr_en), .i_gain_scheme_select(mode), .i_direct_gain_code(code),
        .i_low_power_mode(lp), .i_profile_pin_disable(pdis), .i_profile_register_choice(choice),
        .i_profile_select_pins(pins), .i_ramp_trigger_pin(trig), .i_ramp_reverse_pin(rev),
        .o_gain_code(gain), .o_atten_setting(atten), .o_lna_setting(lna), .o_gain_db_x8(db),
        .o_hold_atten(hold), .o_ramp_stage(stage));

    // ---
    // checks and waits
    // ---
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t register got %h want %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_gain(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t output got %0d want %0d", $time, got, exp);
        end
    endtask : chk_gain

    // next gain change: value and spacing
    task automatic step_to(input logic [8:0] exp, input int per);
        logic [8:0] last;
        int n;
        last = gain;
        n = 0;
        while (gain === last && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk_gain(gain, exp);
        if (per > 0) chk_gain(9'(n), 9'(per));
    endtask : step_to

    task automatic wait_stage(input logic [3:0] exp);
        int n;
        n = 0;
        while (stage !== exp && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk_gain({5'h0, stage}, {5'h0, exp});
    endtask : wait_stage

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ---
    // main sequence
    // ---
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        // reset values, then an unmapped offset
        for (int s = 0; s < GTM_NUM_SLOT; s++) begin
            host_u.read_reg(GTM_SLOT_ADDR[s], rd);
            chk_reg(rd, s > 7 ? GTM_RST_ATTEN : s[0] ? GTM_RST_STEPS : GTM_RST_LIMITS);
        end
        host_u.read_reg(8'ha3, rd);
        chk_reg(rd, 16'h0);
        host_u.write_reg(GTM_OFS_P0_LIMITS, 16'h1234, 1'b0);
        host_u.read_reg(GTM_OFS_P0_LIMITS, rd);
        chk_reg(rd, GTM_RST_LIMITS);
        host_u.write_reg(GTM_OFS_P0_LIMITS, 16'h1234, 1'b1);
        host_u.read_reg(GTM_OFS_P0_LIMITS, rd);
        chk_reg(rd, 16'h1234);
        // fixed mode boundary codes, both power bases
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            code = 9'(lo[i % 6]);
            lp = (i >= 6);
            eff = (code > GTM_GAIN_MAX) ? 9'h0 : code;
            repeat (2) @(negedge clk);
            chk_gain(gain, eff);
            chk_gain({2'h0, atten}, eff < 64 ? eff : 9'h040);
            chk_gain({1'h0, lna}, eff >= 64 ? 9'(eff - 64) : 9'h0);
            chk_gain(db, 9'(eff + (lp ? 96 : 48)));
        end
        // non-uniform codes hold the last gain
        for (int m = 0; m < 2; m++) begin
            code = 9'd100;
            mode = GTM_MODE_FIXED;
            repeat (2) @(negedge clk);
            mode = m ? GTM_MODE_INT : GTM_MODE_EXT;
            code = 9'd5;
            repeat (3) @(negedge clk);
            chk_gain(gain, 9'd100);
        end
        // hold attenuation on profile 0, none on 1
        mode = GTM_MODE_FIXED;
        code = 9'd10;
        host_u.write_reg(GTM_OFS_ATTEN01, 16'h9400, 1'b1);
        repeat (4) @(negedge clk);
        chk_gain({8'h0, hold}, 9'h1);
        chk_gain({2'h0, atten}, 9'd20);
        pins = 2'h1;
        repeat (4) @(negedge clk);
        chk_gain({2'h0, atten}, 9'd10);
        // ramp on profile 1 chosen by register
        pdis = 1'b1;
        choice = 2'h1;
        host_u.write_reg(GTM_OFS_P1_LIMITS, 16'h0409, 1'b1);
        host_u.write_reg(GTM_OFS_P1_STEPS, 16'h152e, 1'b1);
        mode = GTM_MODE_RAMP;
        repeat (4) @(negedge clk);
        chk_gain(gain, 9'd8);
        host_u.set_pins(1'b1, 1'b0);
        wait_stage(GTM_ST_RISE);
        choice = 2'h2;
        host_u.set_pins(1'b1, 1'b1);
        host_u.set_pins(1'b1, 1'b0);
        step_to(9'd11, 0);
        step_to(9'd14, 4);
        step_to(9'd17, 4);
        step_to(9'd18, 4);
        wait_stage(GTM_ST_HOLD);
        repeat (8) @(negedge clk);
        chk_gain({5'h0, stage}, {5'h0, GTM_ST_HOLD});
        host_u.set_pins(1'b0, 1'b1);
        wait_stage(GTM_ST_FALL);
        step_to(9'd12, 0);
        step_to(9'd8, 2);
        wait_stage(GTM_ST_START);
        host_u.set_pins(1'b0, 1'b0);
        repeat (6) @(negedge clk);
        chk_gain(gain, 9'd0);
        wrap_up();
    end
endmodule : test_time_gain_ramp_engine

bind gtm_gain_engine gtm_engine_props #(.GAIN_W(GAIN_W)) props_u (.i_core_clk, .i_rst_n,
    .i_low_power_mode, .i_gain_scheme_select, .i_direct_gain_code, .o_gain_code,
    .o_atten_setting, .o_lna_setting, .o_gain_db_x8, .o_hold_atten, .o_ramp_stage);
